// file: hw/dpsa_pkg.sv
// Purpose: shared constants for the dual port serial adapter
// Assumes: 25 MHz mclk, AXI4-Lite register access with byte addresses
// Notes: rate codes map to bit-time divisors, rounded to the nearest cycle
`default_nettype none
package dpsa_pkg;
    // clock and timing
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned LOCKOUT_MS = 500;
    localparam int unsigned LOCKOUT_CYCLES = CLK_HZ / 1000 * LOCKOUT_MS;
    localparam int unsigned DIV_W = 18;

    // baud rates and derived bit times in cycles
    localparam int unsigned BAUD_9600 = 9600;
    localparam int unsigned BAUD_4800 = 4800;
    localparam int unsigned BAUD_2400 = 2400;
    localparam int unsigned BAUD_1200 = 1200;
    localparam int unsigned BAUD_300 = 300;
    localparam int unsigned BAUD_200 = 200;
    localparam int unsigned BAUD_150 = 150;
    localparam int unsigned BAUD_110 = 110;
    localparam logic [DIV_W-1:0] DIV_9600 = DIV_W'((CLK_HZ + BAUD_9600 / 2) / BAUD_9600);
    localparam logic [DIV_W-1:0] DIV_4800 = DIV_W'((CLK_HZ + BAUD_4800 / 2) / BAUD_4800);
    localparam logic [DIV_W-1:0] DIV_2400 = DIV_W'((CLK_HZ + BAUD_2400 / 2) / BAUD_2400);
    localparam logic [DIV_W-1:0] DIV_1200 = DIV_W'((CLK_HZ + BAUD_1200 / 2) / BAUD_1200);
    localparam logic [DIV_W-1:0] DIV_300 = DIV_W'((CLK_HZ + BAUD_300 / 2) / BAUD_300);
    localparam logic [DIV_W-1:0] DIV_200 = DIV_W'((CLK_HZ + BAUD_200 / 2) / BAUD_200);
    localparam logic [DIV_W-1:0] DIV_150 = DIV_W'((CLK_HZ + BAUD_150 / 2) / BAUD_150);
    localparam logic [DIV_W-1:0] DIV_110 = DIV_W'((CLK_HZ + BAUD_110 / 2) / BAUD_110);

    // register byte offsets
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_DROPS = 8'h08;

    // config field positions and reset value: 9600, no parity, one stop, both ports
    localparam int unsigned CFG_RATE_LO = 0;
    localparam int unsigned CFG_STOP = 3;
    localparam int unsigned CFG_PAR_EN = 4;
    localparam int unsigned CFG_PAR_SENSE = 5;
    localparam int unsigned CFG_PANEL_USE = 6;
    localparam int unsigned CFG_EXT_USE = 7;
    localparam logic [7:0] CFG_RESET = 8'hC8;

    // status field positions
    localparam int unsigned STS_LOCKOUT = 0;
    localparam int unsigned STS_EXT_ERR = 1;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // binary rate code to bit time; every code is legal
    function automatic logic [DIV_W-1:0] dpsa_rate_div(input logic [2:0] code);
        case (code)
            3'h0: return DIV_9600;
            3'h1: return DIV_4800;
            3'h2: return DIV_2400;
            3'h3: return DIV_1200;
            3'h4: return DIV_300;
            3'h5: return DIV_200;
            3'h6: return DIV_150;
            default: return DIV_110;
        endcase
    endfunction
endpackage
`default_nettype wire

// file: hw/dpsa_uart.sv
// Purpose: one 8-bit serial port, transmitter and receiver, format set at run time
// Assumes: rxd synchronous to mclk; format inputs are sampled at each frame start
// Notes: receiver samples mid-bit and checks only the first stop bit
`default_nettype none
module dpsa_uart
    import dpsa_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic [DIV_W-1:0] bitDiv,
    input wire logic parEn,
    input wire logic parOdd,
    input wire logic twoStop,
    input wire logic txValid,
    input wire logic [7:0] txData,
    output logic txReady,
    output logic txd,
    input wire logic rxd,
    output logic rxValid,
    output logic [7:0] rxData,
    output logic rxErr
);
    typedef enum logic [2:0] {SER_IDLE, SER_START, SER_DATA, SER_PAR, SER_STOP} dpsa_ser_t;

    dpsa_ser_t txState;
    dpsa_ser_t rxState;
    logic [DIV_W-1:0] txCnt;
    logic [DIV_W-1:0] txDiv;
    logic [7:0] txShift;
    logic [7:0] txByte;
    logic [2:0] txBit;
    logic txParBit;
    logic txParEn;
    logic txStopLeft;
    logic txParOdd;
    logic [DIV_W-1:0] rxCnt;
    logic [DIV_W-1:0] rxDiv;
    logic [7:0] rxShift;
    logic [2:0] rxBit;
    logic rxParBit;
    logic rxParEn;
    logic rxParOdd;

    assign txReady = (txState == SER_IDLE);

    // transmitter; format latched per frame so a mid-frame switch change cannot tear it
    always_ff @(posedge mclk) begin
        if (srst) begin
            txState <= SER_IDLE;
            txd <= 1'b1;
            txCnt <= '0;
            txDiv <= '0;
            txShift <= '0;
            txByte <= '0;
            txBit <= '0;
            txParBit <= 1'b0;
            txParEn <= 1'b0;
            txStopLeft <= 1'b0;
            txParOdd <= 1'b0;
        end else if (txState == SER_IDLE) begin
            txd <= 1'b1;
            if (txValid) begin
                txShift <= txData;
                txByte <= txData;
                txParBit <= parOdd ? ~^txData : ^txData;
                txParEn <= parEn;
                txParOdd <= parOdd;
                txStopLeft <= twoStop;
                txDiv <= bitDiv;
                txCnt <= bitDiv - 1'b1;
                txd <= 1'b0;
                txState <= SER_START;
            end
        end else if (txCnt != '0) begin
            txCnt <= txCnt - 1'b1;
        end else begin
            txCnt <= txDiv - 1'b1;
            case (txState)
                SER_START: begin
                    txd <= txShift[0];
                    txBit <= '0;
                    txState <= SER_DATA;
                end
                SER_DATA: begin
                    txShift <= txShift >> 1;
                    txBit <= txBit + 1'b1;
                    if (txBit == 3'h7) begin
                        txd <= txParEn ? txParBit : 1'b1;
                        txState <= txParEn ? SER_PAR : SER_STOP;
                    end else begin
                        txd <= txShift[1];
                    end
                end
                SER_PAR: begin
                    txd <= 1'b1;
                    txState <= SER_STOP;
                end
                default: begin
                    if (txStopLeft) begin
                        txStopLeft <= 1'b0; // second stop bit
                    end else begin
                        txState <= SER_IDLE;
                    end
                end
            endcase
        end
    end

    // receiver; a low start that is gone at mid-bit is treated as noise
    always_ff @(posedge mclk) begin
        rxValid <= 1'b0;
        if (srst) begin
            rxState <= SER_IDLE;
            rxCnt <= '0;
            rxDiv <= '0;
            rxShift <= '0;
            rxBit <= '0;
            rxParBit <= 1'b0;
            rxParEn <= 1'b0;
            rxParOdd <= 1'b0;
            rxData <= '0;
            rxErr <= 1'b0;
        end else if (rxState == SER_IDLE) begin
            if (!rxd) begin
                rxDiv <= bitDiv;
                rxCnt <= bitDiv >> 1;
                rxParEn <= parEn;
                rxParOdd <= parOdd;
                rxState <= SER_START;
            end
        end else if (rxCnt != '0) begin
            rxCnt <= rxCnt - 1'b1;
        end else begin
            rxCnt <= rxDiv - 1'b1;
            case (rxState)
                SER_START: begin
                    rxBit <= '0;
                    rxState <= rxd ? SER_IDLE : SER_DATA;
                end
                SER_DATA: begin
                    rxShift <= {rxd, rxShift[7:1]};
                    rxBit <= rxBit + 1'b1;
                    if (rxBit == 3'h7) begin
                        rxState <= rxParEn ? SER_PAR : SER_STOP;
                    end
                end
                SER_PAR: begin
                    rxParBit <= rxd;
                    rxState <= SER_STOP;
                end
                default: begin
                    rxValid <= 1'b1;
                    rxData <= rxShift;
                    rxErr <= !rxd | (rxParEn & (rxParBit != (rxParOdd ? ~^rxShift : ^rxShift)));
                    rxState <= SER_IDLE;
                end
            endcase
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    stop_level_a: assert property (txState == SER_STOP |-> txd) else $error("stop bit not high");
    // odd sense means data plus parity carry an odd count of ones
    parity_bit_a: assert property (txState == SER_PAR |-> (^txByte ^ txd) == txParOdd)
        else $error("parity bit wrong");
    two_stop_a: assert property (txState == SER_STOP && txCnt == '0 && txStopLeft |=> txState == SER_STOP)
        else $error("second stop bit skipped");
endmodule
`default_nettype wire

// file: hw/dpsa_top.sv
// Purpose: dual port serial adapter sharing one controller port between a panel and an external device
// Assumes: all serial inputs synchronous to mclk; registers over AXI4-Lite
// Notes: no byte buffering; a byte that meets a busy transmitter is dropped and counted
//
// Notes on behaviour
// - external traffic locks the panel out for about half a second; controller keeps running
// - eight external bit rates from 9600 down to 110 baud via three select bits
// - stop select 0 gives two stop bits, 1 gives one stop bit
// - parity enable 0 disables parity, 1 enables generation and checking
// - parity sense 0 selects odd, 1 selects even parity
// - every rate, parity and stop combination is accepted as valid
// - panel port always runs 9600 baud, even parity, one stop bit
// - reset default is 9600, no parity, one stop, both ports active
// - port select marks which ports have equipment; only those are serviced
// - panel and exactly one external device may operate at the same time
`default_nettype none
module dpsa_top
    import dpsa_pkg::*;
#(
    parameter int unsigned LOCKOUT_LEN = LOCKOUT_CYCLES
)
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ctrlRxd,
    output logic ctrlTxd,
    input wire logic panelRxd,
    output logic panelTxd,
    input wire logic extRxd,
    output logic extTxd,
    output logic portLockoutMessage
);
    logic [7:0] cfg;
    logic cfgWritten;
    logic [31:0] lockCnt;
    logic extErrFlag;
    logic [15:0] dropCount;
    logic [7:0] awAddrQ;
    logic [31:0] wDataQ;
    logic [3:0] wStrbQ;
    logic awHeld;
    logic wHeld;
    logic [2:0] rateSelect;
    logic stopBitSelect;
    logic parityEnableSelect;
    logic paritySenseSelect;
    logic panelInUse;
    logic extInUse;
    logic [DIV_W-1:0] extDiv;
    logic ctrlTxReady;
    logic ctrlRxValid;
    logic [7:0] ctrlRxData;
    logic panelTxReady;
    logic panelRxValid;
    logic [7:0] panelRxData;
    logic extTxReady;
    logic extRxValid;
    logic [7:0] extRxData;
    logic extRxErr;
    logic extFwd;
    logic panelFwd;
    logic panelRefused;
    logic ctrlTxValid;
    logic [7:0] ctrlTxData;
    logic toExt;
    logic toPanel;
    logic dropNow;
    logic doWrite;
    logic clearErr;

    // switch fields: rate bits a, b, c are the binary rate code
    assign rateSelect = cfg[CFG_RATE_LO +: 3];
    assign stopBitSelect = cfg[CFG_STOP];
    assign parityEnableSelect = cfg[CFG_PAR_EN];
    assign paritySenseSelect = cfg[CFG_PAR_SENSE];
    assign panelInUse = cfg[CFG_PANEL_USE];
    assign extInUse = cfg[CFG_EXT_USE];
    assign extDiv = dpsa_rate_div(rateSelect);

    // routing: external bytes always win the shared port; panel waits out the lockout
    assign extFwd = extRxValid & extInUse;
    assign panelFwd = panelRxValid & panelInUse & !portLockoutMessage & !extFwd;
    assign panelRefused = panelRxValid & panelInUse & (portLockoutMessage | extFwd);
    assign ctrlTxValid = extFwd | panelFwd;
    assign ctrlTxData = extFwd ? extRxData : panelRxData;
    // replies follow whoever owns the port; no owner in use means the reply is dropped
    assign toExt = ctrlRxValid & extInUse & portLockoutMessage;
    assign toPanel = ctrlRxValid & panelInUse & !portLockoutMessage;
    assign dropNow = panelRefused | (ctrlTxValid & !ctrlTxReady) | (toExt & !extTxReady)
        | (toPanel & !panelTxReady);

    // controller side keeps the panel format, so the controller sees one link format
    dpsa_uart ctrlPort (
        .mclk(mclk),
        .srst(srst),
        .bitDiv(DIV_9600),
        .parEn(1'b1),
        .parOdd(1'b0),
        .twoStop(1'b0),
        .txValid(ctrlTxValid),
        .txData(ctrlTxData),
        .txReady(ctrlTxReady),
        .txd(ctrlTxd),
        .rxd(ctrlRxd),
        .rxValid(ctrlRxValid),
        .rxData(ctrlRxData),
        .rxErr()
    );

    // panel port is fixed at 9600 even one stop, whatever the switches say
    dpsa_uart panelPort (
        .mclk(mclk),
        .srst(srst),
        .bitDiv(DIV_9600),
        .parEn(1'b1),
        .parOdd(1'b0),
        .twoStop(1'b0),
        .txValid(toPanel),
        .txData(ctrlRxData),
        .txReady(panelTxReady),
        .txd(panelTxd),
        .rxd(panelRxd),
        .rxValid(panelRxValid),
        .rxData(panelRxData),
        .rxErr()
    );

    // external port format comes from the switch fields
    dpsa_uart extPort (
        .mclk(mclk),
        .srst(srst),
        .bitDiv(extDiv),
        .parEn(parityEnableSelect),
        .parOdd(!paritySenseSelect),
        .twoStop(!stopBitSelect),
        .txValid(toExt),
        .txData(ctrlRxData),
        .txReady(extTxReady),
        .txd(extTxd),
        .rxd(extRxd),
        .rxValid(extRxValid),
        .rxData(extRxData),
        .rxErr(extRxErr)
    );

    // lockout timer restarts on every forwarded external byte, so a busy device holds the panel off
    always_ff @(posedge mclk) begin
        if (srst) begin
            portLockoutMessage <= 1'b0;
            lockCnt <= '0;
        end else if (extFwd) begin
            portLockoutMessage <= 1'b1;
            lockCnt <= LOCKOUT_LEN - 1;
        end else if (lockCnt != '0) begin
            lockCnt <= lockCnt - 1'b1;
        end else begin
            portLockoutMessage <= 1'b0;
        end
    end

    // status: sticky external receive error, set wins over a same-cycle clear
    always_ff @(posedge mclk) begin
        if (srst) begin
            extErrFlag <= 1'b0;
        end else if (extRxValid & extRxErr & extInUse) begin
            extErrFlag <= 1'b1;
        end else if (clearErr) begin
            extErrFlag <= 1'b0;
        end
    end

    // dropped bytes; the panel resends its own, so only the count is kept
    always_ff @(posedge mclk) begin
        if (srst) begin
            dropCount <= '0;
        end else if (dropNow) begin
            dropCount <= dropCount + 1'b1;
        end
    end

    // write channel: address and data taken in either order, response after both
    assign doWrite = awHeld & wHeld & !s_axi_bvalid;
    assign clearErr = doWrite & (awAddrQ == ADDR_STATUS) & wStrbQ[0] & wDataQ[STS_EXT_ERR];
    always_ff @(posedge mclk) begin
        if (srst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddrQ <= '0;
            wDataQ <= '0;
            wStrbQ <= '0;
        end else begin
            if (!awHeld & !s_axi_bvalid & !s_axi_awready) begin
                s_axi_awready <= 1'b1;
            end
            if (!wHeld & !s_axi_bvalid & !s_axi_wready) begin
                s_axi_wready <= 1'b1;
            end
            if (s_axi_awvalid & s_axi_awready) begin
                awAddrQ <= s_axi_awaddr;
                awHeld <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                wDataQ <= s_axi_wdata;
                wStrbQ <= s_axi_wstrb;
                wHeld <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (doWrite) begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (awAddrQ == ADDR_CONFIG || awAddrQ == ADDR_STATUS || awAddrQ == ADDR_DROPS) begin
                    s_axi_bresp <= RESP_OKAY;
                end else begin
                    s_axi_bresp <= RESP_SLVERR;
                end
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // config register: only byte lane 0 carries fields
    always_ff @(posedge mclk) begin
        if (srst) begin
            cfg <= CFG_RESET;
            cfgWritten <= 1'b0;
        end else if (doWrite & (awAddrQ == ADDR_CONFIG) & wStrbQ[0]) begin
            cfg <= wDataQ[7:0];
            cfgWritten <= 1'b1;
        end
    end

    // read channel: answer one cycle after the address is taken
    always_ff @(posedge mclk) begin
        if (srst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid & s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            if (s_axi_araddr == ADDR_CONFIG) begin
                s_axi_rdata <= {24'h00_0000, cfg};
            end else if (s_axi_araddr == ADDR_STATUS) begin
                s_axi_rdata <= {30'h0000_0000, extErrFlag, portLockoutMessage};
            end else if (s_axi_araddr == ADDR_DROPS) begin
                s_axi_rdata <= {16'h0000, dropCount};
            end else begin
                s_axi_rdata <= '0;
                s_axi_rresp <= RESP_SLVERR;
            end
        end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    lockout_start_a: assert property (extFwd |=> portLockoutMessage && lockCnt == LOCKOUT_LEN - 1)
        else $error("lockout not started by external byte");
    lockout_hold_a: assert property (portLockoutMessage && lockCnt != '0 |=> portLockoutMessage)
        else $error("lockout ended early");
    panel_block_a: assert property (portLockoutMessage |-> !panelFwd && !toPanel)
        else $error("panel served during lockout");
    cfg_default_a: assert property (!cfgWritten |-> cfg == CFG_RESET)
        else $error("config left default without a write");
    rate_range_a: assert property (extDiv >= DIV_9600 && extDiv <= DIV_110)
        else $error("external bit time out of range");
    port_select_a: assert property (ctrlTxValid |-> (extFwd && extInUse) || (panelFwd && panelInUse))
        else $error("unused port serviced");
    reply_route_a: assert property (ctrlRxValid && extInUse && portLockoutMessage |-> toExt && !toPanel)
        else $error("reply not routed to external device");
    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");

    ext_byte_c: cover property (extFwd);
    panel_refused_c: cover property (panelRefused);
    reply_ext_c: cover property (toExt);
    ext_error_c: cover property (extErrFlag);
endmodule
`default_nettype wire

// file: testbench/dpsa_peer.sv
// Purpose: serial party on one adapter link, sends and receives frames
// Assumes: bit time given in mclk cycles
// Notes: line rests high between frames, as an idle serial line does
`default_nettype none
module dpsa_peer (
    input wire logic mclk,
    input wire logic rxLine,
    output logic txLine
);
    timeunit 1ns;
    timeprecision 1ns;
    initial txLine = 1'b1;
    // frame: start, 8 data lsb first, optional parity, stops
    task automatic sendByte(input logic [7:0] d, input logic pe, input logic odd, input logic two, input int div);
        logic q[$];
        q = {1'b0};
        for (int i = 0; i < 8; i++) q.push_back(d[i]);
        if (pe) q.push_back(^d ^ odd);
        q.push_back(1'b1);
        if (two) q.push_back(1'b1);
        foreach (q[i]) begin
            @(posedge mclk);
            txLine <= q[i];
            repeat (div - 1) @(posedge mclk);
        end
    endtask
    // mid-bit sampling; reads one parity and one stop bit
    task automatic recvByte(input int div, output logic [7:0] d, output logic p, output logic s);
        @(negedge rxLine);
        repeat (div / 2) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            repeat (div) @(posedge mclk);
            d[i] = rxLine;
        end
        repeat (div) @(posedge mclk);
        p = rxLine;
        repeat (div) @(posedge mclk);
        s = rxLine;
    endtask
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// Purpose: self-checking bench for the dual port serial adapter
// Assumes: 40 ns mclk; lockout shortened through LOCKOUT_LEN
// Notes: reply and panel frames run beside the forwarded frame so the run stays short
`default_nettype none
module tb_top
    import dpsa_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LOCK = 8000;
    localparam int BIT = int'(DIV_9600);
    logic mclk = 1'b0, srst = 1'b1, panelRxd;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic ctrlRxd, ctrlTxd, extRxd, extTxd, panelTxd, portLockoutMessage;
    int errors = 0, samples_checked = 0, cycles = 0, seed = 44207;
    dpsa_top #(.LOCKOUT_LEN(LOCK)) dut (.mclk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .ctrlRxd, .ctrlTxd, .panelRxd, .panelTxd, .extRxd, .extTxd, .portLockoutMessage);
    dpsa_peer extDev (.mclk, .rxLine(extTxd), .txLine(extRxd));
    dpsa_peer ctlDev (.mclk, .rxLine(ctrlTxd), .txLine(ctrlRxd));
    dpsa_peer panelDev (.mclk, .rxLine(panelTxd), .txLine(panelRxd));
    always #20 mclk = ~mclk;
    // hang guard just above the roughly 96k cycles the three tests take
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 100000) begin
            errors++;
            complete_run();
        end
    end
    task automatic checkVal(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // address and data offered together, each released when taken
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w;
        aw = 1;
        w = 1;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw || w) begin
            @(posedge mclk);
            if (aw && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (w && s_axi_wready) s_axi_wvalid <= 1'b0;
            aw = aw && s_axi_awready !== 1'b1;
            w = w && s_axi_wready !== 1'b1;
        end
        do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge mclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] b, got, b2, got2;
        logic p, s, p2, s2;
        int n;
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        // defaults, unmapped place, every rate code with random other fields
        axiRead(ADDR_CONFIG, d, r);
        checkVal("config reset", 32'h0000_00C8, d);
        axiWrite(8'h0C, 32'h0000_00FF, r);
        checkVal("unmapped wr", 32'h0000_0002, 32'(r));
        axiRead(8'h0C, d, r);
        checkVal("unmapped rd", 32'h0000_0002, 32'(r));
        for (int c = 0; c < 8; c++) begin
            b = (8'($random(seed)) & 8'hF8) | 8'(c);
            axiWrite(ADDR_CONFIG, {24'h0, b}, r);
            checkVal("config resp", 32'h0000_0000, 32'(r));
            axiRead(ADDR_CONFIG, d, r);
            checkVal("config read", {24'h0, b}, d);
        end
        $display("test registers done");
        // ext marked unused: its byte must go nowhere and lock nothing
        axiWrite(ADDR_CONFIG, 32'h0000_0048, r);
        n = 0;
        fork
            extDev.sendByte(8'h00, 1'b0, 1'b0, 1'b1, BIT);
            repeat (BIT * 12) begin
                @(posedge mclk);
                n += int'(ctrlTxd !== 1'b1 || portLockoutMessage !== 1'b0);
            end
        join
        checkVal("unused ext", 0, 32'(n));
        $display("test port select done");
        // ext at odd parity, two stops; ctrl side must still carry 8E1
        axiWrite(ADDR_CONFIG, 32'h0000_00D0, r);
        b = 8'($random(seed));
        b2 = 8'($random(seed));
        fork
            begin
                extDev.sendByte(b, 1'b1, 1'b1, 1'b0, BIT);
                checkVal("lockout on", 1, 32'(portLockoutMessage));
                axiRead(ADDR_STATUS, d, r);
                checkVal("status", 32'h0000_0001, d);
                n = 0;
                while (portLockoutMessage === 1'b1) begin
                    @(posedge mclk);
                    n++;
                end
                // counting starts about half a bit after the receiver took the byte
                checkVal("lockout len", 1, 32'(n > LOCK - BIT / 2 - 8 && n < LOCK - BIT / 2 + 8));
            end
            ctlDev.recvByte(BIT, got, p, s);
            // reply lands in the same cycle as the ext byte, before the lockout, so the panel gets it
            ctlDev.sendByte(b2, 1'b1, 1'b0, 1'b0, BIT);
            panelDev.recvByte(BIT, got2, p2, s2);
            // panel holds its request while it shows busy, then sends it once free
            begin
                wait (portLockoutMessage === 1'b1);
                wait (portLockoutMessage === 1'b0);
                panelDev.sendByte(~b2, 1'b1, 1'b0, 1'b0, BIT);
            end
        join
        checkVal("ctrl data", 32'(b), 32'(got));
        checkVal("ctrl parity", 32'(^b), 32'(p));
        checkVal("ctrl stop", 1, 32'(s));
        checkVal("panel data", 32'(b2), 32'(got2));
        checkVal("panel parity", 32'(^b2), 32'(p2));
        checkVal("panel stop", 1, 32'(s2));
        axiRead(ADDR_DROPS, d, r);
        checkVal("drops", 0, d);
        checkVal("resend start", 0, 32'(ctrlTxd));
        $display("test forward done");
        complete_run();
    end
endmodule
`default_nettype wire
